// ===== core/gtu_consts.vh
`ifndef GTU_CONSTS_VH
`define GTU_CONSTS_VH

// Word indices of the registers; byte address is four times the index
`define GTU_IDX_CTRL0 6'h00
`define GTU_IDX_CNT0 6'h05
`define GTU_IDX_CAPTURE_RELOAD_REG 6'h0a
`define GTU_IDX_STAT 6'h0b

// Control word fields, one control word per timer
`define GTU_CTRL_W 17
`define GTU_F_SEL 2:0
`define GTU_F_MODE 4:3
`define GTU_F_RUN 5
`define GTU_F_DOWN 6
`define GTU_F_EXTDIR 7
`define GTU_F_GATE 8
`define GTU_F_EDGE 10:9
`define GTU_F_CONCAT 11
`define GTU_F_FUNC 13:12
`define GTU_F_RELOAD 12
`define GTU_F_TRIG 15:14
`define GTU_F_TRIG_RISE 14
`define GTU_F_TRIG_FALL 15
`define GTU_F_CLR 16

// Timer modes
`define GTU_MODE_TIMER 2'b00
`define GTU_MODE_COUNTER 2'b01
`define GTU_MODE_GATED 2'b10
`define GTU_MODE_INCR 2'b11

// Auxiliary timer functions in the first module
`define GTU_FN_TIMER 2'b00
`define GTU_FN_CAPTURE 2'b01
`define GTU_FN_RELOAD 2'b10

// Prescaler: factor is 2 to the power (selection + shift)
`define GTU_PRE_W 10
`define GTU_PRE1_SHIFT 4'h3
`define GTU_PRE2_SHIFT 4'h2

// Reset values, all-ones wrap value and count step
`define GTU_CTRL_RST 17'h00000
`define GTU_CNT_RST 16'h0000
`define GTU_CNT_MAX 16'hffff
`define GTU_CNT_ONE 16'h0001

// Bus responses
`define GTU_RESP_OKAY 2'b00
`define GTU_RESP_SLVERR 2'b10

`endif

// ===== core/gtu_general_timer_unit.v
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "gtu_consts.vh"
module gtu_general_timer_unit (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [4:0] timer_input_pin,
	input wire [4:0] direction_pin,
	input wire capture_input_pin,
	output wire core_one_output_pin,
	output wire core_two_output_pin,
	output wire compare_unit_clock
);

	// Timer index: 0 aux lo, 1 core one, 2 aux hi, 3 aux two, 4 core two
	reg [`GTU_CTRL_W-1:0] ctrl_r [0:4];
	reg [15:0] cnt_r [0:4];
	reg [15:0] capture_reload_reg_r;
	reg lat1_r;
	reg lat2_r;
	reg cmp_clk_r;
	reg [`GTU_PRE_W-1:0] pre_r;

	// Pin synchroniser stages: bits 4:0 input, 9:5 direction, 10 capture
	reg [10:0] sy1_r;
	reg [10:0] sy2_r;
	reg [10:0] sy3_r;
	wire [10:0] rise_w;
	wire [10:0] fall_w;

	wire [4:0] step_w;
	wire [4:0] dn_w;
	wire [4:0] wrap_w;
	wire [4:0] cap_w;
	wire [4:0] rld_w;
	wire [4:0] wr_ctrl_w;
	wire [4:0] wr_cnt_w;
	wire l1r_w;
	wire l1f_w;
	wire l2r_w;
	wire l2f_w;
	wire cap2_w;

	// Bus slave state
	reg aw_full_r;
	reg w_full_r;
	reg [7:0] aw_addr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg bvalid_r;
	reg [1:0] bresp_r;
	reg rvalid_r;
	reg [31:0] rdata_r;
	reg [1:0] rresp_r;
	reg [31:0] rd_data_c;
	reg rd_err_c;
	wire [5:0] widx_w;
	wire [5:0] rd_idx_w;
	wire [5:0] rd_off_w;
	wire wr_go_w;
	wire wr_capture_reload_reg_w;
	wire wr_err_w;
	integer i;
	integer j;

	// Select rising, falling or both edges
	function edge_hit;
		input [1:0] e;
		input r;
		input f;
		begin
			edge_hit = (e[0] & r) | (e[1] & f);
		end
	endfunction

	// One tick every 2^(sel+sh) clocks of the free prescaler
	function pre_hit;
		input [2:0] sel;
		input [3:0] sh;
		input [`GTU_PRE_W-1:0] p;
		reg [10:0] m;
		begin
			m = (11'h001 << (sel + sh)) - 11'h001;
			pre_hit = (({1'b0, p} & m) == m);
		end
	endfunction

	// Byte-lane merge of a 16-bit field
	function [15:0] mrg16;
		input [15:0] o;
		input [15:0] n;
		input [1:0] s;
		begin
			mrg16 = {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
		end
	endfunction

	// Outputs come straight from flip-flops
	assign core_one_output_pin = lat1_r;
	assign core_two_output_pin = lat2_r;
	assign compare_unit_clock = cmp_clk_r;

	// Free-running prescaler shared by all timers
	always @(posedge aclk) begin
		if (!aresetn) begin
			pre_r <= 10'h000;
		end else begin
			pre_r <= pre_r + 10'h001;
		end
	end

	// Two-stage synchroniser plus one history stage for edges
	always @(posedge aclk) begin
		if (!aresetn) begin
			sy1_r <= 11'h000;
			sy2_r <= 11'h000;
			sy3_r <= 11'h000;
		end else begin
			sy1_r <= {capture_input_pin, direction_pin, timer_input_pin};
			sy2_r <= sy1_r;
			sy3_r <= sy2_r;
		end
	end

	// Edges only from the settled stages
	assign rise_w = sy2_r & ~sy3_r;
	assign fall_w = ~sy2_r & sy3_r;

	// Toggle latch transitions, seen in the wrap cycle itself
	assign l1r_w = wrap_w[1] & ~lat1_r;
	assign l1f_w = wrap_w[1] & lat1_r;
	assign l2r_w = wrap_w[4] & ~lat2_r;
	assign l2f_w = wrap_w[4] & lat2_r;

	// Per-timer step, direction and trigger logic
	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1) begin : tmr
			localparam [3:0] SH = (g < 3) ? `GTU_PRE1_SHIFT : `GTU_PRE2_SHIFT;
			localparam AUX1 = (g == 0) || (g == 2);
			localparam AUX = AUX1 || (g == 3);
			localparam [5:0] CI = `GTU_IDX_CTRL0 + g;
			localparam [5:0] NI = `GTU_IDX_CNT0 + g;
			wire [`GTU_CTRL_W-1:0] c;
			wire tick;
			wire lr;
			wire lf;
			wire pe;
			wire ext;
			wire quad;
			wire up_q;
			wire gate;
			wire held;
			reg mode_step;

			assign c = ctrl_r[g];
			// Prescaled tick, factor set by the 3-bit selection
			assign tick = pre_hit(c[`GTU_F_SEL], SH, pre_r);
			assign lr = (g == 3) ? l2r_w : l1r_w;
			assign lf = (g == 3) ? l2f_w : l1f_w;
			assign pe = edge_hit(c[`GTU_F_EDGE], rise_w[g], fall_w[g]);
			// Count source: own pin or the core toggle latch
			assign ext = (AUX && c[`GTU_F_CONCAT]) ? edge_hit(c[`GTU_F_EDGE], lr, lf) : pe;
			// Any edge of A or B is a quadrature step
			assign quad = (sy2_r[g] ^ sy3_r[g]) | (sy2_r[5+g] ^ sy3_r[5+g]);
			assign up_q = sy2_r[g] ^ sy3_r[5+g];
			// Input pin doubles as gate level
			assign gate = (sy2_r[g] == c[`GTU_F_GATE]);
			// Capture or reload function freezes aux lo or aux hi
			assign held = AUX1 && (c[`GTU_F_FUNC] != `GTU_FN_TIMER);

			// Step source by mode
			always @* begin
				case (c[`GTU_F_MODE])
					`GTU_MODE_TIMER: mode_step = tick;
					`GTU_MODE_COUNTER: mode_step = ext;
					`GTU_MODE_GATED: mode_step = tick & gate;
					`GTU_MODE_INCR: mode_step = quad;
					default: mode_step = 1'b0;
				endcase
			end

			assign step_w[g] = c[`GTU_F_RUN] & ~held & mode_step;
			// Software direction, inverted by a high direction pin
			assign dn_w[g] = (c[`GTU_F_MODE] == `GTU_MODE_INCR) ? ~up_q :
				c[`GTU_F_DOWN] ^ (c[`GTU_F_EXTDIR] & sy2_r[5+g]);
			// Up from all ones or down from zero wraps
			assign wrap_w[g] = step_w[g] &
				(dn_w[g] ? (cnt_r[g] == `GTU_CNT_RST) : (cnt_r[g] == `GTU_CNT_MAX));
			// Aux capture of core one on its own pin
			assign cap_w[g] = AUX1 && (c[`GTU_F_FUNC] == `GTU_FN_CAPTURE) && pe;
			// Aux reload of core one on pin or chosen latch edge
			assign rld_w[g] = AUX1 && (c[`GTU_F_FUNC] == `GTU_FN_RELOAD) &&
				(pe | (c[`GTU_F_TRIG_RISE] & l1r_w) | (c[`GTU_F_TRIG_FALL] & l1f_w));
			assign wr_ctrl_w[g] = wr_go_w && (widx_w == CI);
			assign wr_cnt_w[g] = wr_go_w && (widx_w == NI);
		end
	endgenerate

	// Capture into the capture/reload register from a chosen source
	assign cap2_w = (ctrl_r[3][`GTU_F_FUNC] == 2'b00) ?
		edge_hit(ctrl_r[3][`GTU_F_TRIG], rise_w[10], fall_w[10]) :
		(ctrl_r[3][12] & edge_hit(ctrl_r[3][`GTU_F_TRIG], rise_w[1], fall_w[1])) |
		(ctrl_r[3][13] & edge_hit(ctrl_r[3][`GTU_F_TRIG], rise_w[6], fall_w[6]));

	// Counters, captures, reloads and latches; bus writes win last
	always @(posedge aclk) begin
		if (!aresetn) begin
			for (i = 0; i < 5; i = i + 1) begin
				cnt_r[i] <= `GTU_CNT_RST;
			end
			capture_reload_reg_r <= `GTU_CNT_RST;
			lat1_r <= 1'b0;
			lat2_r <= 1'b0;
			cmp_clk_r <= 1'b0;
		end else begin
			for (i = 0; i < 5; i = i + 1) begin
				if (step_w[i]) begin
					cnt_r[i] <= dn_w[i] ? cnt_r[i] - `GTU_CNT_ONE : cnt_r[i] + `GTU_CNT_ONE;
				end
			end
			if (cap_w[0]) begin
				cnt_r[0] <= cnt_r[1];
			end
			if (cap_w[2]) begin
				cnt_r[2] <= cnt_r[1];
			end
			// Aux lo has priority if both reload at once
			if (rld_w[0]) begin
				cnt_r[1] <= cnt_r[0];
			end else if (rld_w[2]) begin
				cnt_r[1] <= cnt_r[2];
			end
			if (wrap_w[4] && ctrl_r[4][`GTU_F_RELOAD]) begin
				cnt_r[4] <= capture_reload_reg_r;
			end
			if (cap2_w) begin
				capture_reload_reg_r <= cnt_r[3];
				if (ctrl_r[3][`GTU_F_CLR]) begin
					cnt_r[3] <= `GTU_CNT_RST;
				end
			end
			lat1_r <= lat1_r ^ wrap_w[1];
			lat2_r <= lat2_r ^ wrap_w[4];
			cmp_clk_r <= wrap_w[4];
			for (i = 0; i < 5; i = i + 1) begin
				if (wr_cnt_w[i]) begin
					cnt_r[i] <= mrg16(cnt_r[i], wdata_r[15:0], wstrb_r[1:0]);
				end
			end
			if (wr_capture_reload_reg_w) begin
				capture_reload_reg_r <= mrg16(capture_reload_reg_r, wdata_r[15:0], wstrb_r[1:0]);
			end
		end
	end

	// Control registers
	always @(posedge aclk) begin
		if (!aresetn) begin
			for (j = 0; j < 5; j = j + 1) begin
				ctrl_r[j] <= `GTU_CTRL_RST;
			end
		end else begin
			for (j = 0; j < 5; j = j + 1) begin
				if (wr_ctrl_w[j]) begin
					ctrl_r[j] <= {wstrb_r[2] ? wdata_r[16] : ctrl_r[j][16],
						mrg16(ctrl_r[j][15:0], wdata_r[15:0], wstrb_r[1:0])};
				end
			end
		end
	end

	// Write decode: fires once both address and data are held and no write response is pending
	assign widx_w = aw_addr_r[7:2];
	assign wr_go_w = aw_full_r & w_full_r & ~bvalid_r;
	assign wr_capture_reload_reg_w = wr_go_w && (widx_w == `GTU_IDX_CAPTURE_RELOAD_REG);
	assign wr_err_w = (widx_w > `GTU_IDX_STAT);

	// Handshakes: each channel ready while its holding slot is empty
	assign s_axi_awready = ~aw_full_r;
	assign s_axi_wready = ~w_full_r;
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// Write channel: address and data taken in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_addr_r <= 8'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `GTU_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_full_r) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_r) begin
				w_full_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go_w) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_err_w ? `GTU_RESP_SLVERR : `GTU_RESP_OKAY;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// Read address decode
	assign rd_idx_w = s_axi_araddr[7:2];
	assign rd_off_w = rd_idx_w - `GTU_IDX_CNT0;

	// Read data mux; status shows latches and live directions
	always @* begin
		rd_data_c = 32'h00000000;
		rd_err_c = 1'b0;
		if (rd_idx_w < `GTU_IDX_CNT0) begin
			rd_data_c = {15'h0000, ctrl_r[rd_idx_w[2:0]]};
		end else if (rd_idx_w < `GTU_IDX_CAPTURE_RELOAD_REG) begin
			rd_data_c = {16'h0000, cnt_r[rd_off_w[2:0]]};
		end else if (rd_idx_w == `GTU_IDX_CAPTURE_RELOAD_REG) begin
			rd_data_c = {16'h0000, capture_reload_reg_r};
		end else if (rd_idx_w == `GTU_IDX_STAT) begin
			rd_data_c = {25'h0000000, dn_w, lat2_r, lat1_r};
		end else begin
			rd_err_c = 1'b1;
		end
	end

	// Read channel: answer one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `GTU_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && !rvalid_r) begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_data_c;
				rresp_r <= rd_err_c ? `GTU_RESP_SLVERR : `GTU_RESP_OKAY;
			end else if (rvalid_r && s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

endmodule

// ===== dv/gtu_props.sv
`timescale 1ns/1ps
// Bus handshake and compare clock checks on the top ports
module gtu_props (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire core_two_output_pin,
	input wire compare_unit_clock
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_b_done: assert property (p_b_done) else $error("write response repeated");
	property p_b_block; $rose(s_axi_bvalid) |-> s_axi_awready && s_axi_wready; endproperty
	a_b_block: assert property (p_b_block) else $error("write slots not freed with response");
	property p_ar_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data not held");
	property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_r_block: assert property (p_r_block) else $error("read accepted during answer");
	property p_r_err; s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0; endproperty
	a_r_err: assert property (p_r_err) else $error("error read data not zero");
	property p_cuc_wrap; $changed(core_two_output_pin) |-> ##[0:1] compare_unit_clock; endproperty
	a_cuc_wrap: assert property (p_cuc_wrap) else $error("no compare clock on wrap");
	property p_cuc_len; compare_unit_clock |=> !compare_unit_clock; endproperty
	a_cuc_len: assert property (p_cuc_len) else $error("compare clock too long");
endmodule

// ===== dv/gtu_pin_model.sv
`timescale 1ns/1ps
// Far-side pin driver: follows requested levels, each level standing at least HOLD+1 cycles
module gtu_pin_model #(
	parameter HOLD = 20
) (
	input wire aclk,
	input wire [4:0] lvl_tin,
	input wire [4:0] lvl_dir,
	input wire lvl_cap,
	output reg [4:0] timer_input_pin = 5'h00,
	output reg [4:0] direction_pin = 5'h00,
	output reg capture_input_pin = 1'b0
);
	integer hold_r = 0;
	// A new level waits until the previous one has stood long enough
	always @(posedge aclk) begin
		if (hold_r != 0)
			hold_r <= hold_r - 1;
		else if ({lvl_tin, lvl_dir, lvl_cap} != {timer_input_pin, direction_pin, capture_input_pin}) begin
			{timer_input_pin, direction_pin, capture_input_pin} <= {lvl_tin, lvl_dir, lvl_cap};
			hold_r <= HOLD;
		end
	end
endmodule

// ===== dv/gtu_general_timer_unit_tb.sv
`timescale 1ns/1ps
module gtu_general_timer_unit_tb;
	reg aclk = 1'b0;
	reg aresetn = 1'b0;
	reg [7:0] awaddr = 8'h00;
	reg [7:0] araddr = 8'h00;
	reg [31:0] wdata = 32'h0;
	reg awvalid = 1'b0;
	reg wvalid = 1'b0;
	reg bready = 1'b0;
	reg arvalid = 1'b0;
	reg rready = 1'b0;
	reg [4:0] lt = 5'h00;
	reg [4:0] ld = 5'h00;
	reg lc = 1'b0;
	wire awready, wready, bvalid, arready, rvalid, p1, p2, cuc, cin;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [4:0] tin, din;
	integer errors = 0;
	integer tests_run = 0;
	integer cyc = 0;
	integer s, n;
	reg [31:0] d, d0;
	reg [1:0] r;
	reg l, seen;
	always #4 aclk = ~aclk;
	always @(negedge aclk) cyc <= cyc + 1;
	gtu_general_timer_unit dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_input_pin(tin),
		.direction_pin(din), .capture_input_pin(cin), .core_one_output_pin(p1), .core_two_output_pin(p2),
		.compare_unit_clock(cuc));
	gtu_pin_model #(.HOLD(20)) pm (.aclk(aclk), .lvl_tin(lt), .lvl_dir(ld), .lvl_cap(lc),
		.timer_input_pin(tin), .direction_pin(din), .capture_input_pin(cin));
	// Compare and count
	task chk(input [31:0] g, input [31:0] e);
		begin
			tests_run = tests_run + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("wrong value at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	// Bus write of one word, response code into r
	task wr(input [5:0] i, input [31:0] v);
		reg a, w, b;
		begin
			@(posedge aclk);
			awaddr <= {i, 2'b00};
			wdata <= v;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			b = 1'b0;
			while (!b) begin
				@(negedge aclk);
				a = awvalid & awready;
				w = wvalid & wready;
				b = bvalid;
				r = bresp;
				@(posedge aclk);
				if (a) awvalid <= 1'b0;
				if (w) wvalid <= 1'b0;
			end
			bready <= 1'b0;
		end
	endtask
	// Bus read of one word into d and r
	task rd(input [5:0] i);
		reg a, v;
		begin
			@(posedge aclk);
			araddr <= {i, 2'b00};
			arvalid <= 1'b1;
			rready <= 1'b1;
			v = 1'b0;
			while (!v) begin
				@(negedge aclk);
				a = arvalid & arready;
				v = rvalid;
				d = rdata;
				r = rresp;
				@(posedge aclk);
				if (a) arvalid <= 1'b0;
			end
			rready <= 1'b0;
		end
	endtask
	// Two pin edges, index 5 is the capture pin
	task pulse(input integer k);
		repeat (2) begin
			@(posedge aclk);
			if (k == 5) lc <= ~lc;
			else lt[k] <= ~lt[k];
			repeat (30) @(posedge aclk);
		end
	endtask
	// Count change over exactly five prescaled periods
	task rate(input [5:0] t, input [31:0] c, input integer f, input [15:0] e);
		integer c0;
		begin
			wr(t, c);
			c0 = cyc;
			rd(t + 6'h05);
			d0 = d;
			while (cyc < c0 + 5 * f) @(posedge aclk);
			rd(t + 6'h05);
			chk((d - d0) & 32'hffff, {16'h0, e});
		end
	endtask
	// Core one wraps from a loaded count and its latch flips
	task wrap1(input [31:0] c, input [31:0] v);
		begin
			wr(6'h01, 32'h0);
			wr(6'h06, v);
			l = p1;
			wr(6'h01, c);
			for (n = 0; n < 40 && p1 === l; n = n + 1) @(negedge aclk);
			chk(p1, !l);
		end
	endtask
	// One quadrature state on aux lo pins, A on input, B on direction
	task qstep(input a, input b);
		begin
			@(posedge aclk);
			lt[0] <= a;
			ld[0] <= b;
			repeat (30) @(posedge aclk);
		end
	endtask
	// Aux lo in incremental mode: four steps forward, two back
	task incr;
		begin
			wr(6'h05, 32'h0);
			wr(6'h00, 32'h38);
			qstep(1'b1, 1'b0);
			qstep(1'b1, 1'b1);
			qstep(1'b0, 1'b1);
			qstep(1'b0, 1'b0);
			qstep(1'b0, 1'b1);
			qstep(1'b1, 1'b1);
			rd(6'h05);
			chk(d, 32'h2);
		end
	endtask
	// Core one reloads from aux lo on latch rise and from aux hi on fall
	task pwm;
		integer k;
		begin
			wr(6'h01, 32'h0);
			wr(6'h00, 32'h6000);
			wr(6'h02, 32'ha000);
			wr(6'h05, 32'hfffc);
			wr(6'h07, 32'hfffe);
			wr(6'h06, 32'hffff);
			wr(6'h01, 32'h24);
			for (k = 0; k < 2; k = k + 1) begin
				l = p1;
				for (n = 0; n < 700 && p1 === l; n = n + 1) @(negedge aclk);
				rd(6'h06);
				chk(d, l ? 32'hfffe : 32'hfffc);
			end
		end
	endtask
	// Closing verdict
	task report_and_stop;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, errors);
			if (errors == 0 && tests_run > 0) $display("verification passed");
			else $display("verification failed");
			$finish;
		end
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge aclk);
		errors = errors + 1;
		report_and_stop;
	end
	// Main sequence
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(6'h0b);
		chk(d, 32'h0);
		rd(6'h0c);
		chk(r, 2'b10);
		chk(d, 32'h0);
		wr(6'h0c, 32'h1);
		chk(r, 2'b10);
		wr(6'h00, 32'h228);
		repeat (3) pulse(0);
		rd(6'h05);
		chk(d, 32'h3);
		wr(6'h02, 32'h130);
		@(posedge aclk) lt[2] <= 1'b1;
		repeat (80) @(posedge aclk);
		lt[2] <= 1'b0;
		repeat (10) @(posedge aclk);
		rd(6'h07);
		chk(d, 32'ha);
		for (s = 0; s < 3; s = s + 1) rate(6'h01, 32'h20 | s, 8 << s, 16'h0005);
		ld[4] <= 1'b1;
		for (s = 0; s < 3; s = s + 1) rate(6'h04, 32'ha0 | s, 4 << s, 16'hfffb);
		wrap1(32'h20, 32'hffff);
		wrap1(32'h60, 32'h0);
		wr(6'h01, 32'h0);
		wr(6'h06, 32'h1234);
		wr(6'h02, 32'h1200);
		pulse(2);
		rd(6'h07);
		chk(d, 32'h1234);
		wr(6'h05, 32'habcd);
		wr(6'h00, 32'h2200);
		pulse(0);
		rd(6'h06);
		chk(d, 32'habcd);
		wr(6'h08, 32'h5555);
		wr(6'h03, 32'h14000);
		pulse(5);
		rd(6'h0a);
		chk(d, 32'h5555);
		rd(6'h08);
		chk(d, 32'h0);
		wr(6'h08, 32'h6666);
		wr(6'h03, 32'h05000);
		pulse(1);
		rd(6'h0a);
		chk(d, 32'h6666);
		incr;
		pwm;
		wr(6'h04, 32'h0);
		wr(6'h0a, 32'h0777);
		wr(6'h09, 32'hffff);
		wr(6'h08, 32'h0);
		wr(6'h03, 32'he28);
		l = p2;
		wr(6'h04, 32'h1027);
		for (n = 0; n < 1200 && p2 === l; n = n + 1) @(negedge aclk);
		seen = 1'b0;
		repeat (3) begin
			if (cuc === 1'b1) seen = 1'b1;
			@(negedge aclk);
		end
		chk(p2, !l);
		chk(seen, 1'b1);
		rd(6'h09);
		chk(d, 32'h0777);
		rd(6'h08);
		chk(d, 32'h1);
		report_and_stop;
	end
endmodule
bind gtu_general_timer_unit gtu_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .core_two_output_pin(core_two_output_pin),
	.compare_unit_clock(compare_unit_clock));
